//--- hdl/trs_defines.svh
// constants for the range-learning controller
`ifndef TRS_DEFINES_SVH
`define TRS_DEFINES_SVH

// ==========================================================
// timing
`define TRS_CLK_KHZ      64'd250000
`define TRS_ENTER_MS     64'd5000
`define TRS_FACTORY_MS   64'd10000
`define TRS_CAPTURE_MS   64'd2000
`define TRS_BLINK_MS     64'd250
`define TRS_DEBOUNCE_MS  64'd5
`define TRS_MS2CYC(ms)   (32'((ms) * `TRS_CLK_KHZ))

// ==========================================================
// converter codes, 16 bit; current scale is 0..24 mA
`define TRS_I_UNDER      16'h2666
`define TRS_I_MIN        16'h2AAB
`define TRS_I_MAX        16'hD555
`define TRS_I_OVER       16'hEAAB
`define TRS_V_MIN        16'h0000
`define TRS_V_MAX        16'hFFFF

// ==========================================================
// factory range: start a quarter turn out, 25 turns long
`define TRS_DEF_START_SHIFT 2
`define TRS_DEF_TRAVEL_REVS 25
`define TRS_KEY_BOTH     2'h3
`define TRS_KEY_START    2'h1
`define TRS_KEY_STOP     2'h2
`define TRS_KEY_NONE     2'h0

`endif

//--- hdl/trs_pkg.sv
// types shared by the range-learning controller
package trs_pkg;
  typedef enum logic [1:0] {
    CURRENT_LOOP_VARIANT,
    LOW_VOLTAGE_VARIANT,
    HIGH_VOLTAGE_VARIANT
  } trs_variant_t;

  typedef enum {
    ST_NORMAL, ST_ENTER_HOLD, ST_LEARN, ST_FIRST, ST_SECOND_HELD, ST_RELEASE
  } trs_state_t;
endpackage

//--- hdl/trs_key_if.sv
// debounced key levels between filter and controller
`timescale 1ns/1ns
interface trs_key_if;
  logic startKey;
  logic stopKey;
  modport filter (output startKey, output stopKey);
  modport ctrl   (input  startKey, input  stopKey);
endinterface

//--- hdl/trs_key_filter.sv
// synchroniser and debouncer for keys and external inputs
`timescale 1ns/1ns
`include "trs_defines.svh"
module trs_key_filter #(
  parameter int unsigned DEBOUNCE_CYC = `TRS_MS2CYC(`TRS_DEBOUNCE_MS)
) (
  input  wire logic [1:0] keyRaw,
  input  wire logic [1:0] extRaw,
  input  wire logic       clk,
  input  wire logic       rst,
  trs_key_if.filter       keys
);
  logic [1:0] level;

  generate
    if (DEBOUNCE_CYC < 2)
      $error("trs_key_filter: debounce count too small");
    for (genvar i = 0; i < 2; i++)
    begin : g_chan
      logic [2:0]  keySync;
      logic [2:0]  extSync;
      logic        raw;
      logic        stable;
      logic [31:0] cnt;
      // three stages; second and third must agree before a change counts
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          keySync <= 3'h0;
          extSync <= 3'h0;
          raw     <= 1'b0;
        end
        else
        begin
          keySync <= {keySync[1:0], keyRaw[i]};
          extSync <= {extSync[1:0], extRaw[i]};
          if ((keySync[1] == keySync[2]) && (extSync[1] == extSync[2]))
            raw <= keySync[2] | extSync[2];
        end
      end
      // level must hold a full debounce window before it is accepted
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          cnt    <= 32'h0;
          stable <= 1'b0;
        end
        else if (raw == stable)
          cnt <= 32'h0;
        else if (cnt == DEBOUNCE_CYC - 1)
        begin
          cnt    <= 32'h0;
          stable <= raw;
        end
        else
          cnt <= cnt + 32'h1;
      end
      assign level[i] = stable;
    end
  endgenerate

  assign keys.startKey = level[0];
  assign keys.stopKey  = level[1];
endmodule

//--- hdl/trs_range_scaler.sv
// maps position onto the converter code across learned limits
`timescale 1ns/1ns
`include "trs_defines.svh"
module trs_range_scaler
  import trs_pkg::*;
#(
  parameter int POS_W    = 24,
  parameter int REV_BITS = 12
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      enable,
  input  trs_variant_t                   variant,
  input  wire logic [POS_W-1:0]          position,
  input  wire logic [POS_W-1:0]          startLim,
  input  wire logic [POS_W-1:0]          stopLim,
  output logic      [15:0]               code,
  output logic                           lowOver,
  output logic                           highOver,
  output logic      [POS_W-REV_BITS:0]   spanRevs
);
  localparam int RW = POS_W - REV_BITS + 1;

  // smallest power of two not below n
  function automatic logic [RW-1:0] pow2Ceil(input logic [RW-1:0] n);
    logic [RW-1:0] p;
    p = {{(RW-1){1'b0}}, 1'b1};
    for (int k = 0; k < RW - 1; k++)
      if (p < n)
        p = p << 1;
    return p;
  endfunction

  logic                     rising;
  logic [POS_W-1:0]         travel;
  logic signed [POS_W:0]    rel;
  logic [POS_W+15:0]        prod;
  logic [15:0]              lo;
  logic [15:0]              hi;
  logic [15:0]              under;
  logic [15:0]              over;
  logic [RW-1:0]            revs;
  logic [15:0]              next_code;

  // direction follows where start was captured relative to stop
  always_comb
  begin
    rising = stopLim >= startLim;
    travel = rising ? stopLim - startLim : startLim - stopLim;
    rel    = rising ? $signed({1'b0, position}) - $signed({1'b0, startLim})
                    : $signed({1'b0, startLim}) - $signed({1'b0, position});
    lo     = (variant == CURRENT_LOOP_VARIANT) ? `TRS_I_MIN   : `TRS_V_MIN;
    hi     = (variant == CURRENT_LOOP_VARIANT) ? `TRS_I_MAX   : `TRS_V_MAX;
    under  = (variant == CURRENT_LOOP_VARIANT) ? `TRS_I_UNDER : `TRS_V_MIN;
    over   = (variant == CURRENT_LOOP_VARIANT) ? `TRS_I_OVER  : `TRS_V_MAX;
    revs   = RW'((travel + POS_W'((1 << REV_BITS) - 1)) >> REV_BITS);
    prod   = (POS_W+16)'(rel[POS_W-1:0]) * (POS_W+16)'(hi - lo);
    if (rel < 0)
      next_code = under;
    else if (rel > $signed({1'b0, travel}))
      next_code = over;
    else if (travel == '0)
      next_code = lo;
    else
      next_code = lo + 16'(prod / (POS_W+16)'(travel));
  end

  // registered so the converter never sees the divider settle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      code     <= 16'h0000;
      lowOver  <= 1'b0;
      highOver <= 1'b0;
      spanRevs <= '0;
    end
    else
    begin
      code     <= enable ? next_code : 16'h0000;
      lowOver  <= enable && (rel < 0);
      highOver <= enable && (rel > $signed({1'b0, travel}));
      spanRevs <= pow2Ceil(revs);
    end
  end
endmodule

//--- hdl/trs_range_learning_procedure.sv
// range-learning controller: key timing, states, indicators, limits
`timescale 1ns/1ns
`include "trs_defines.svh"
module trs_range_learning_procedure
  import trs_pkg::*;
#(
  parameter int          POS_W        = 24,
  parameter int          REV_BITS     = 12,
  parameter int unsigned ENTER_CYC    = `TRS_MS2CYC(`TRS_ENTER_MS),
  parameter int unsigned FACTORY_CYC  = `TRS_MS2CYC(`TRS_FACTORY_MS),
  parameter int unsigned CAPTURE_CYC  = `TRS_MS2CYC(`TRS_CAPTURE_MS),
  parameter int unsigned BLINK_CYC    = `TRS_MS2CYC(`TRS_BLINK_MS),
  parameter int unsigned DEBOUNCE_CYC = `TRS_MS2CYC(`TRS_DEBOUNCE_MS)
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     startKey,
  input  wire logic                     stopKey,
  input  wire logic                     startInput,
  input  wire logic                     stopInput,
  input  wire logic [POS_W-1:0]         position,
  input  trs_variant_t                  variant,
  output logic                          primaryIndicator,
  output logic                          secondaryIndicator,
  output logic                          analogEnable,
  output logic      [15:0]              analogCode,
  output logic                          lowOvertravel,
  output logic                          highOvertravel,
  output logic      [POS_W-REV_BITS:0]  spanRevs,
  output logic                          learning,
  output logic                          userSettings
);
  // ==========================================================
  // parameter checks
  generate
    if (REV_BITS < 3 || REV_BITS >= POS_W - 4)
      $error("trs_range_learning_procedure: REV_BITS does not fit POS_W");
    if (ENTER_CYC >= FACTORY_CYC || CAPTURE_CYC < 2 || BLINK_CYC < 2)
      $error("trs_range_learning_procedure: hold thresholds out of order");
  endgenerate

  localparam logic [POS_W-1:0] DEF_START =
    POS_W'(1) << (REV_BITS - `TRS_DEF_START_SHIFT);
  localparam logic [POS_W-1:0] DEF_STOP =
    DEF_START + (POS_W'(`TRS_DEF_TRAVEL_REVS) << REV_BITS);

  // ==========================================================
  // key filtering
  trs_key_if keys ();

  trs_key_filter #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_filter (
    .keyRaw (
      {stopKey, startKey}),
    .extRaw (
      {stopInput, startInput}),
    .clk    (clk),
    .rst    (rst),
    .keys   (keys.filter)
  );

  logic [1:0] pattern;
  assign pattern = {keys.stopKey, keys.startKey};

  // ==========================================================
  // hold timer
  logic [1:0]  prevPattern;
  logic [31:0] holdCnt;

  // restarts on every change of key pattern, saturates when held
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prevPattern <= `TRS_KEY_NONE;
      holdCnt     <= 32'h0;
    end
    else
    begin
      prevPattern <= pattern;
      if (pattern != prevPattern || pattern == `TRS_KEY_NONE)
        holdCnt <= 32'h0;
      else if (holdCnt != 32'hFFFF_FFFF)
        holdCnt <= holdCnt + 32'h1;
    end
  end

  logic enterHit;
  logic factoryHit;
  logic startHit;
  logic stopHit;
  logic bothNow;

  // single-cycle strobes plus the bothNow level; equality keeps each strobe firing once per hold
  assign enterHit   = pattern == `TRS_KEY_BOTH  && holdCnt == ENTER_CYC;
  assign factoryHit = pattern == `TRS_KEY_BOTH  && holdCnt == FACTORY_CYC;
  assign startHit   = pattern == `TRS_KEY_START && holdCnt == CAPTURE_CYC;
  assign stopHit    = pattern == `TRS_KEY_STOP  && holdCnt == CAPTURE_CYC;
  assign bothNow    = pattern == `TRS_KEY_BOTH;

  // ==========================================================
  // blink source
  logic [31:0] blinkCnt;
  logic        blink;

  // free running, so both blinking lights stay in phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      blinkCnt <= 32'h0;
      blink    <= 1'b0;
    end
    else if (blinkCnt == BLINK_CYC - 1)
    begin
      blinkCnt <= 32'h0;
      blink    <= ~blink;
    end
    else
      blinkCnt <= blinkCnt + 32'h1;
  end

  // ==========================================================
  // procedure state
  trs_state_t state;
  trs_state_t next_state;
  logic       firstIsStart;
  logic       second;

  assign second = firstIsStart ? stopHit : startHit;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_NORMAL:
        if (enterHit)
          next_state = ST_ENTER_HOLD;
      ST_ENTER_HOLD:
        if (factoryHit)
          next_state = ST_RELEASE;
        else if (pattern == `TRS_KEY_NONE)
          next_state = ST_LEARN;
      ST_LEARN:
        if (bothNow)
          next_state = ST_RELEASE;
        else if (startHit || stopHit)
          next_state = ST_FIRST;
      ST_FIRST:
        if (second)
          next_state = ST_SECOND_HELD;
      ST_SECOND_HELD:
        if (pattern == `TRS_KEY_NONE)
          next_state = ST_NORMAL;
      ST_RELEASE:
        if (pattern == `TRS_KEY_NONE)
          next_state = ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= ST_NORMAL;
    else
      state <= next_state;
  end

  // ==========================================================
  // limit capture
  logic [POS_W-1:0] firstPos;
  logic [POS_W-1:0] startLim;
  logic [POS_W-1:0] stopLim;

  // first capture only remembers; nothing is committed until the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      firstPos     <= '0;
      firstIsStart <= 1'b1;
    end
    else if (state == ST_LEARN && !bothNow && (startHit || stopHit))
    begin
      firstPos     <= position;
      firstIsStart <= startHit;
    end
  end

  // committed range; aborting leaves it and the settings mode intact
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      startLim     <= DEF_START;
      stopLim      <= DEF_STOP;
      userSettings <= 1'b0;
    end
    else if (state == ST_ENTER_HOLD && factoryHit)
    begin
      startLim     <= DEF_START;
      stopLim      <= DEF_STOP;
      userSettings <= 1'b0;
    end
    else if (state == ST_FIRST && second)
    begin
      if (position == firstPos)
      begin
        startLim     <= DEF_START;
        stopLim      <= DEF_STOP;
        userSettings <= 1'b0;
      end
      else
      begin
        startLim     <= firstIsStart ? firstPos : position;
        stopLim      <= firstIsStart ? position : firstPos;
        userSettings <= 1'b1;
      end
    end
  end

  // ==========================================================
  // indicators and output gate
  logic next_primary;
  logic next_secondary;
  logic next_learning;

  always_comb
  begin
    next_learning = 1'b0;
    unique case (state)
      ST_ENTER_HOLD:
      begin
        next_primary   = 1'b1;
        next_secondary = 1'b1;
        next_learning  = 1'b1;
      end
      ST_LEARN:
      begin
        next_primary   = blink;
        next_secondary = blink;
        next_learning  = 1'b1;
      end
      ST_FIRST:
      begin
        next_primary   = firstIsStart ? 1'b1 : blink;
        next_secondary = firstIsStart ? blink : 1'b1;
        next_learning  = 1'b1;
      end
      ST_SECOND_HELD:
      begin
        next_primary   = 1'b1;
        next_secondary = 1'b1;
      end
      default:
      begin
        next_primary   = userSettings;
        next_secondary = ~userSettings;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      primaryIndicator   <= 1'b0;
      secondaryIndicator <= 1'b0;
      learning           <= 1'b0;
      analogEnable       <= 1'b0;
    end
    else
    begin
      primaryIndicator   <= next_primary;
      secondaryIndicator <= next_secondary;
      learning           <= next_learning;
      analogEnable       <= ~next_learning;
    end
  end

  // ==========================================================
  // output scaling
  trs_range_scaler #(
    .POS_W    (POS_W),
    .REV_BITS (REV_BITS)
  ) u_scaler (
    .clk      (clk),
    .rst      (rst),
    .enable   (analogEnable),
    .variant  (variant),
    .position (position),
    .startLim (startLim),
    .stopLim  (stopLim),
    .code     (analogCode),
    .lowOver  (lowOvertravel),
    .highOver (highOvertravel),
    .spanRevs (spanRevs)
  );
endmodule

//--- sim/trs_operator.sv
// operator or machine controller at the keys and the start/stop inputs
`timescale 1ns/1ns
module trs_operator (
  input  wire logic clk,
  input  wire logic useExt,
  input  wire logic wantStart,
  input  wire logic wantStop,
  output logic      startKey,
  output logic      stopKey,
  output logic      startInput,
  output logic      stopInput
);
  // one source at a time, so each path is seen on its own
  always @(negedge clk)
  begin
    startKey   <= wantStart & ~useExt;
    stopKey    <= wantStop & ~useExt;
    startInput <= wantStart & useExt;
    stopInput  <= wantStop & useExt;
  end
endmodule

//--- sim/trs_range_learning_procedure_props.sv
// concurrent checks on the range-learning controller ports
`timescale 1ns/1ns
`include "trs_defines.svh"
module trs_range_learning_procedure_props
  import trs_pkg::*;
#(
  parameter int ENTER_CYC = 50,
  parameter int BLINK_CYC = 4
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        startKey,
  input wire logic        stopKey,
  input wire logic        startInput,
  input wire logic        stopInput,
  input trs_variant_t     variant,
  input wire logic        primaryIndicator,
  input wire logic        secondaryIndicator,
  input wire logic        analogEnable,
  input wire logic [15:0] analogCode,
  input wire logic        lowOvertravel,
  input wire logic        highOvertravel,
  input wire logic        learning,
  input wire logic        userSettings
);
  localparam int BLINK_WIN = BLINK_CYC + 1;
  logic [31:0] bothCnt;
  logic [4:0]  idleCnt;
  wire         bothDown = (startKey | startInput) & (stopKey | stopInput);
  wire         anyDown = startKey | startInput | stopKey | stopInput;
  // =====================================================
  // hold and idle counters, saturating so long runs stay sane
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bothCnt <= 32'h0;
      idleCnt <= 5'h0;
    end
    else
    begin
      bothCnt <= bothDown ? ((bothCnt == 32'hFFFF_FFFF) ? bothCnt : bothCnt + 32'h1) : 32'h0;
      idleCnt <= anyDown ? 5'h0 : (idleCnt == 5'h1F ? idleCnt : idleCnt + 5'h1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // =====================================================
  // properties
  sequence s_keysIdle;
    idleCnt >= 5'd16;
  endsequence
  sequence s_toggle;
    primaryIndicator != $past(primaryIndicator) ||
    secondaryIndicator != $past(secondaryIndicator);
  endsequence
  property p_learnOff;
    learning |-> !analogEnable;
  endproperty
  a_learnOff: assert property (p_learnOff)
    else $error("output enabled while learning");
  property p_codeZero;
    !analogEnable && $past(analogEnable) == 1'b0 |-> analogCode == 16'h0000
      && !lowOvertravel && !highOvertravel;
  endproperty
  a_codeZero: assert property (p_codeZero)
    else $error("code not zero while output off");
  property p_enterInd;
    $rose(learning) |-> primaryIndicator && secondaryIndicator;
  endproperty
  a_enterInd: assert property (p_enterInd)
    else $error("entry without both indicators lit");
  property p_enterHold;
    $rose(learning) |-> bothCnt >= ENTER_CYC;
  endproperty
  a_enterHold: assert property (p_enterHold)
    else $error("entry before the hold time");
  property p_curOver;
    analogEnable && $past(analogEnable) && variant == CURRENT_LOOP_VARIANT
      && $stable(variant) |-> (!lowOvertravel || analogCode == `TRS_I_UNDER)
      && (!highOvertravel || analogCode == `TRS_I_OVER);
  endproperty
  a_curOver: assert property (p_curOver)
    else $error("wrong current overtravel code");
  property p_voltOver;
    analogEnable && $past(analogEnable) && variant != CURRENT_LOOP_VARIANT
      && $stable(variant) |-> (!lowOvertravel || analogCode == `TRS_V_MIN)
      && (!highOvertravel || analogCode == `TRS_V_MAX);
  endproperty
  a_voltOver: assert property (p_voltOver)
    else $error("wrong voltage overtravel code");
  property p_idleInd;
    s_keysIdle and !learning |-> userSettings ?
      (primaryIndicator && !secondaryIndicator) : (!primaryIndicator && secondaryIndicator);
  endproperty
  a_idleInd: assert property (p_idleInd)
    else $error("wrong indicators in normal operation");
  property p_blink;
    s_keysIdle and learning |-> ##[1:BLINK_WIN] s_toggle;
  endproperty
  a_blink: assert property (p_blink)
    else $error("no indicator blinking while learning");
endmodule

bind trs_range_learning_procedure trs_range_learning_procedure_props #(.ENTER_CYC(ENTER_CYC), .BLINK_CYC(BLINK_CYC))
  i_trs_range_learning_procedure_props (.clk(clk), .rst(rst), .startKey(startKey), .stopKey(stopKey),
  .startInput(startInput), .stopInput(stopInput), .variant(variant),
  .primaryIndicator(primaryIndicator), .secondaryIndicator(secondaryIndicator),
  .analogEnable(analogEnable), .analogCode(analogCode), .lowOvertravel(lowOvertravel),
  .highOvertravel(highOvertravel), .learning(learning), .userSettings(userSettings));

//--- sim/trs_range_learning_procedure_tb.sv
// self-checking bench for the range-learning controller
`timescale 1ns/1ns
`include "trs_defines.svh"
module trs_range_learning_procedure_tb;
  import trs_pkg::*;
  localparam int EN = 50;
  localparam int FA = 100;
  localparam int CA = 20;
  localparam int TURN = 4096;
  logic         clk;
  logic         rst;
  logic         useExt;
  logic         wantStart;
  logic         wantStop;
  logic         startKey;
  logic         stopKey;
  logic         startInput;
  logic         stopInput;
  logic [23:0]  position;
  trs_variant_t variant;
  logic         primaryIndicator;
  logic         secondaryIndicator;
  logic         analogEnable;
  logic [15:0]  analogCode;
  logic         lowOvertravel;
  logic         highOvertravel;
  logic [12:0]  spanRevs;
  logic         learning;
  logic         userSettings;
  int           fails;
  int           cmpCount;

  trs_operator i_trs_operator (.clk(clk), .useExt(useExt), .wantStart(wantStart),
    .wantStop(wantStop), .startKey(startKey), .stopKey(stopKey),
    .startInput(startInput), .stopInput(stopInput));
  trs_range_learning_procedure #(.ENTER_CYC(EN), .FACTORY_CYC(FA), .CAPTURE_CYC(CA), .BLINK_CYC(4),
    .DEBOUNCE_CYC(3)) i_trs_range_learning_procedure (.clk(clk), .rst(rst), .startKey(startKey),
    .stopKey(stopKey), .startInput(startInput), .stopInput(stopInput),
    .position(position), .variant(variant), .primaryIndicator(primaryIndicator),
    .secondaryIndicator(secondaryIndicator), .analogEnable(analogEnable),
    .analogCode(analogCode), .lowOvertravel(lowOvertravel),
    .highOvertravel(highOvertravel), .spanRevs(spanRevs), .learning(learning),
    .userSettings(userSettings));

  // =====================================================
  // clock and helpers
  always #2 clk = ~clk;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // hold a pattern; nonblocking so the operator takes it one edge later, race free
  task automatic press(input logic [1:0] pat, input int n, input logic ext);
    useExt <= ext;
    wantStart <= pat[0];
    wantStop <= pat[1];
    repeat (n) @(negedge clk);
  endtask

  // release and outlast filter plus output latency
  task automatic idle();
    wantStart <= 1'b0;
    wantStop <= 1'b0;
    repeat (24) @(negedge clk);
  endtask

  function automatic logic [15:0] expCode(input int rel, input int tr);
    longint lo;
    longint hi;
    lo = (variant == CURRENT_LOOP_VARIANT) ? 64'h2AAB : 64'h0;
    hi = (variant == CURRENT_LOOP_VARIANT) ? 64'hD555 : 64'hFFFF;
    return 16'(lo + rel * (hi - lo) / tr);
  endfunction

  function automatic int expSpan(input int t);
    int s;
    s = 1;
    while (s < t)
      s = s * 2;
    return s;
  endfunction

  // overtravel code of the current variant
  function automatic logic [15:0] expOver(input logic below);
    if (variant == CURRENT_LOOP_VARIANT)
      return below ? `TRS_I_UNDER : `TRS_I_OVER;
    return below ? `TRS_V_MIN : `TRS_V_MAX;
  endfunction

  // enter, capture both limits in the given order, release
  task automatic learn(input logic [23:0] ps, input logic [23:0] pt, input logic sFirst);
    press(2'h3, EN + 20, 1'($urandom_range(1)));
    check({learning, primaryIndicator, secondaryIndicator, analogEnable}, 24'hE);
    idle();
    check(learning, 1'b1);
    position = sFirst ? ps : pt;
    press(sFirst ? 2'h1 : 2'h2, CA + 20, 1'($urandom_range(1)));
    check(sFirst ? primaryIndicator : secondaryIndicator, 1'b1);
    idle();
    press(2'h3, 30, 1'b0);
    idle();
    check(learning, 1'b1);
    position = sFirst ? pt : ps;
    press(sFirst ? 2'h2 : 2'h1, CA + 20, 1'($urandom_range(1)));
    check({learning, primaryIndicator, secondaryIndicator, analogEnable}, 24'h7);
    idle();
    check({userSettings, primaryIndicator, secondaryIndicator},
      (ps != pt) ? 24'h6 : 24'h1);
  endtask

  // position at rel counts from start toward stop; checks code and flags
  task automatic probe(input logic [23:0] ps, input int dir, input int rel, input int tr);
    position = 24'(int'(ps) + dir * rel);
    repeat (4) @(negedge clk);
    check({lowOvertravel, highOvertravel}, {rel < 0, rel > tr});
    if (rel >= 0 && rel <= tr)
      check(analogCode, expCode(rel, tr));
    else
      check(analogCode, expOver(rel < 0));
  endtask

  // =====================================================
  // main sequence
  initial
  begin
    int turns;
    int tr;
    int dir;
    logic [23:0] ps;
    clk = 1'b0;
    rst = 1'b1;
    {useExt, wantStart, wantStop} = 3'h0;
    position = 24'h000000;
    variant = CURRENT_LOOP_VARIANT;
    fails = 0;
    cmpCount = 0;
    void'($urandom(52));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check({userSettings, primaryIndicator, secondaryIndicator, analogEnable}, 24'h3);
    // abort before any limit keeps factory range
    press(2'h3, EN + 20, 1'b1);
    check(learning, 1'b1);
    idle();
    press(2'h3, 30, 1'b0);
    idle();
    check({learning, userSettings, primaryIndicator, secondaryIndicator}, 24'h1);
    // every order, direction and variant
    for (int i = 0; i < 4; i++)
    begin
      turns = (i == 0) ? 4 : int'($urandom_range(40, 1));
      tr = turns * TURN;
      variant = trs_variant_t'(i % 3);
      dir = i[1] ? -1 : 1;
      ps = 24'h100000 + 24'($urandom_range(4095)) + (i[1] ? 24'(tr) : 24'h0);
      learn(ps, 24'(int'(ps) + dir * tr), i[0]);
      check(spanRevs, 24'(expSpan(turns)));
      probe(ps, dir, -1, tr);
      probe(ps, dir, 0, tr);
      probe(ps, dir, tr / 2, tr);
      probe(ps, dir, int'($urandom_range(tr - 1, 1)), tr);
      probe(ps, dir, tr, tr);
      probe(ps, dir, tr + 1, tr);
    end
    // abort with a learned range in use keeps that range
    press(2'h3, EN + 20, 1'b0);
    idle();
    press(2'h3, 30, 1'b1);
    idle();
    check({learning, userSettings, primaryIndicator, secondaryIndicator}, 24'h6);
    probe(ps, dir, tr / 2, tr);
    // long hold wipes the learned range
    press(2'h3, FA + 30, 1'($urandom_range(1)));
    idle();
    check({learning, userSettings, primaryIndicator, secondaryIndicator}, 24'h1);
    learn(24'h123456, 24'h123456, 1'b1);
    end_sim();
  end

  // cut a hang short
  initial
  begin
    #40000;
    fails++;
    end_sim();
  end
endmodule
